// ---- rtl/program_sequencer_pkg.sv ----
package program_sequencer_pkg;

	localparam int ADDR_W = 32;
	localparam int WORD_W = 32;
	localparam int STACK_DEPTH = 15;
	localparam int SP_W = 4;
	localparam int LOOP_FLAG_BIT = 15;
	localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
	localparam logic [WORD_W-1:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [WORD_W-1:0] LOOP_COUNT_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] LOOP_END_RESET = 32'h0000_0000;
	localparam logic [WORD_W-1:0] LOOP_COUNT_LAST = 32'h0000_0001;
	localparam logic [ADDR_W-1:0] PC_STEP = 32'h0000_0001;
	localparam logic [SP_W-1:0] SP_EMPTY = 4'h0;
	localparam logic [SP_W-1:0] SP_FULL = 4'hF;
	localparam logic [SP_W-1:0] SP_STEP = 4'h1;

	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_IRQ_FETCH1 = 3'h1,
		ST_IRQ_FETCH2 = 3'h3,
		ST_IRQ_DECIDE = 3'h2,
		ST_LOOP_SAVE2 = 3'h6,
		ST_LOOP_POP2 = 3'h4
	} seq_state_type;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_CALL = 3'h1,
		OP_RETURN_SUB = 3'h2,
		OP_RETURN_IRQ = 3'h3,
		OP_LOOP_START = 3'h4,
		OP_JUMP = 3'h5
	} seq_op_type;

	typedef struct packed {
		seq_op_type op;
		logic [ADDR_W-1:0] target;
		logic [WORD_W-1:0] count;
		logic [ADDR_W-1:0] loopEnd;
	} seq_cmd_type;

	typedef struct packed {
		logic [ADDR_W-1:0] first;
		logic [ADDR_W-1:0] second;
	} irq_vec_type;

	typedef struct packed {
		logic isJsr;
		logic [ADDR_W-1:0] target;
	} fetched_word_type;

	typedef struct packed {
		logic [WORD_W-1:0] hi;
		logic [WORD_W-1:0] lo;
	} stack_entry_type;

endpackage : program_sequencer_pkg

// ---- rtl/program_sequencer.sv ----
// What this block does
// - program counter is 32 bits wide, covering the full program space.
// - system stack is internal, 15 entries of 64 bits, implicitly addressed.
// - call or long interrupt pushes program counter and status word together.
// - return from subroutine pops top entry, restoring only the program counter.
// - return from interrupt pops top entry, restoring program counter and status word.
// - decode instruction finishes on interrupt unless first of two words: abort, refetch.
// - interrupt controller supplies two fetch addresses; program counter held meanwhile.
// - a jump-to-subroutine in either interrupt word makes a long interrupt with stacking.
// - otherwise fast interrupt: no stack use, resume from unchanged program counter.
// - loop start first pushes current loop count and loop end address.
// - then loop count and end address load from the loop-start instruction.
// - then loop body start address and status word are pushed.
// - loop flag in status word enables program counter versus end address compare.
// - body follows loop start; at end address the count is tested for one.
// - count not one: decrement and copy top entry to program counter, no pop.
// - count one: step on, restore flag from top, drop it, pop loop registers.
// - loop end restores stack pointer to its value before the loop.
`timescale 1ns/1ps
module program_sequencer
	import program_sequencer_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cmdValid,
	input seq_cmd_type cmd,
	output logic cmdReady,
	input wire logic irqReq,
	input irq_vec_type irqVec,
	output logic irqTaken,
	input wire logic decodeFirstOfTwo,
	input wire logic [ADDR_W-1:0] decodeAddr,
	output logic decodeAbort,
	input fetched_word_type fetchedWord,
	output logic [ADDR_W-1:0] fetchAddr,
	output logic fetchValid,
	output logic [ADDR_W-1:0] program_counter,
	output logic [WORD_W-1:0] status_word,
	output logic [WORD_W-1:0] loop_count_reg,
	output logic [ADDR_W-1:0] loop_end_address_reg,
	output logic [SP_W-1:0] stackPointer,
	output logic longIrq,
	output logic stackError
);

	seq_state_type state_q, state_d;
	logic [ADDR_W-1:0] pc_q, pc_d;
	logic [WORD_W-1:0] status_q, status_d;
	logic [WORD_W-1:0] count_q, count_d;
	logic [ADDR_W-1:0] endAddr_q, endAddr_d;
	logic [SP_W-1:0] sp_q, sp_d;
	logic [ADDR_W-1:0] fetchAddr_q, fetchAddr_d;
	logic fetchValid_q, fetchValid_d;
	logic jsrSeen_q, jsrSeen_d;
	logic [ADDR_W-1:0] jsrTarget_q, jsrTarget_d;
	logic abort_q, abort_d;
	logic longIrq_q, longIrq_d;
	logic stackError_q;
	logic doPush, doPop;
	logic pushOk, popOk;
	stack_entry_type pushData;
	stack_entry_type stackMem [DEPTH];
	stack_entry_type topEntry;
	logic cmdTake, irqTake, loopHit;

	function automatic logic [SP_W-1:0] topIndex(input logic [SP_W-1:0] sp);
		topIndex = sp - SP_STEP;
	endfunction : topIndex

	function automatic logic canPush(input logic [SP_W-1:0] sp);
		canPush = (sp != SP_FULL);
	endfunction : canPush

	function automatic logic canPop(input logic [SP_W-1:0] sp);
		canPop = (sp != SP_EMPTY);
	endfunction : canPop

	function automatic logic [WORD_W-1:0] withLoopFlag(input logic [WORD_W-1:0] status,
		input logic flag);
		withLoopFlag = status;
		withLoopFlag[LOOP_FLAG_BIT] = flag;
	endfunction : withLoopFlag

	// stack location is implied by the pointer, never by an operand
	assign topEntry = !canPop(sp_q) ? '0 : stackMem[topIndex(sp_q)];
	assign cmdReady = (state_q == ST_RUN);
	assign cmdTake = cmdValid && (state_q == ST_RUN);
	// the instruction in decode completes first, so the interrupt waits for a free cycle
	assign irqTake = irqReq && (state_q == ST_RUN) && !cmdValid;
	assign irqTaken = irqTake;
	assign loopHit = status_q[LOOP_FLAG_BIT] && (pc_q == endAddr_q);
	// the stack only moves when there is room for a push or an entry to pop
	assign pushOk = doPush && canPush(sp_q);
	assign popOk = doPop && canPop(sp_q);

	// next-state and datapath decisions for one instruction slot
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		status_d = status_q;
		count_d = count_q;
		endAddr_d = endAddr_q;
		fetchAddr_d = pc_q;
		fetchValid_d = 1'b1;
		jsrSeen_d = jsrSeen_q;
		jsrTarget_d = jsrTarget_q;
		abort_d = 1'b0;
		longIrq_d = 1'b0;
		doPush = 1'b0;
		doPop = 1'b0;
		pushData = '0;
		case (state_q)
			ST_RUN: begin
				pc_d = pc_q + PC_STEP;
				if (cmdTake) begin
					fetchValid_d = 1'b0;
					case (cmd.op)
						OP_CALL: begin
							// the return address is the word that would have come next
							doPush = 1'b1;
							pushData = '{hi: pc_q, lo: status_q};
							pc_d = cmd.target;
						end
						OP_RETURN_SUB: begin
							doPop = 1'b1;
							pc_d = topEntry.hi;
						end
						OP_RETURN_IRQ: begin
							// status comes back together with the counter
							doPop = 1'b1;
							pc_d = topEntry.hi;
							status_d = topEntry.lo;
						end
						OP_LOOP_START: begin
							doPush = 1'b1;
							pushData = '{hi: endAddr_q, lo: count_q};
							count_d = cmd.count;
							endAddr_d = cmd.loopEnd;
							// counter held: the body start goes onto the stack next cycle
							pc_d = pc_q;
							state_d = ST_LOOP_SAVE2;
						end
						OP_JUMP: begin
							pc_d = cmd.target;
						end
						default: begin
							fetchValid_d = 1'b1;
						end
					endcase
				end else if (irqTake) begin
					// program counter frozen; a split two-word instruction restarts at its address
					pc_d = decodeFirstOfTwo ? decodeAddr : pc_q;
					abort_d = decodeFirstOfTwo;
					// the controller's first address goes out on the very next fetch
					fetchAddr_d = irqVec.first;
					jsrSeen_d = 1'b0;
					state_d = ST_IRQ_FETCH1;
				end else if (loopHit) begin
					// at the end address either branch back or fall out of the loop
					if (count_q != LOOP_COUNT_LAST) begin
						count_d = count_q - LOOP_COUNT_LAST;
						pc_d = topEntry.hi;
					end else begin
						doPop = 1'b1;
						status_d = withLoopFlag(status_q, topEntry.lo[LOOP_FLAG_BIT]);
						state_d = ST_LOOP_POP2;
					end
				end
			end
			ST_LOOP_SAVE2: begin
				// body starts at the word after the loop-start instruction
				doPush = 1'b1;
				pushData = '{hi: pc_q, lo: status_q};
				status_d = withLoopFlag(status_q, 1'b1);
				fetchValid_d = 1'b0;
				state_d = ST_RUN;
			end
			ST_LOOP_POP2: begin
				// second pop brings back the outer loop's registers
				doPop = 1'b1;
				endAddr_d = topEntry.hi;
				count_d = topEntry.lo;
				fetchValid_d = 1'b0;
				state_d = ST_RUN;
			end
			ST_IRQ_FETCH1: begin
				fetchAddr_d = irqVec.second;
				state_d = ST_IRQ_FETCH2;
			end
			ST_IRQ_FETCH2: begin
				// the word from the first address arrives now; resuming waits for the decision
				fetchValid_d = 1'b0;
				if (fetchedWord.isJsr) begin
					jsrSeen_d = 1'b1;
					jsrTarget_d = fetchedWord.target;
				end
				state_d = ST_IRQ_DECIDE;
			end
			ST_IRQ_DECIDE: begin
				// the word from the second address arrives now
				state_d = ST_RUN;
				if (jsrSeen_q || fetchedWord.isJsr) begin
					doPush = 1'b1;
					pushData = '{hi: pc_q, lo: status_q};
					pc_d = jsrSeen_q ? jsrTarget_q : fetchedWord.target;
					fetchValid_d = 1'b0;
					longIrq_d = 1'b1;
				end
				// fast service leaves the counter untouched and skips the stack
				jsrSeen_d = 1'b0;
			end
			default: begin
				state_d = ST_RUN;
				fetchValid_d = 1'b0;
			end
		endcase
	end

	// a push on a full stack or a pop on an empty one leaves the pointer where it is
	always_comb begin
		sp_d = sp_q;
		if (pushOk) begin
			sp_d = sp_q + SP_STEP;
		end else if (popOk) begin
			sp_d = sp_q - SP_STEP;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_RUN;
			jsrSeen_q <= 1'b0;
			jsrTarget_q <= PC_RESET;
			abort_q <= 1'b0;
			longIrq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			jsrSeen_q <= jsrSeen_d;
			jsrTarget_q <= jsrTarget_d;
			abort_q <= abort_d;
			longIrq_q <= longIrq_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pc_q <= PC_RESET;
			status_q <= STATUS_RESET;
			count_q <= LOOP_COUNT_RESET;
			endAddr_q <= LOOP_END_RESET;
		end else begin
			pc_q <= pc_d;
			status_q <= status_d;
			count_q <= count_d;
			endAddr_q <= endAddr_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fetchAddr_q <= PC_RESET;
			fetchValid_q <= 1'b0;
		end else begin
			fetchAddr_q <= fetchAddr_d;
			fetchValid_q <= fetchValid_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sp_q <= SP_EMPTY;
			stackError_q <= 1'b0;
		end else begin
			sp_q <= sp_d;
			if ((doPush && !pushOk) || (doPop && !popOk)) begin
				stackError_q <= 1'b1;
			end
		end
	end

	// push writes the entry above the current top
	always_ff @(posedge ref_clk) begin
		if (pushOk) begin
			stackMem[sp_q] <= pushData;
		end
	end

	// every data output comes straight from a flip-flop
	assign fetchAddr = fetchAddr_q;
	assign fetchValid = fetchValid_q;
	assign program_counter = pc_q;
	assign status_word = status_q;
	assign loop_count_reg = count_q;
	assign loop_end_address_reg = endAddr_q;
	assign stackPointer = sp_q;
	assign decodeAbort = abort_q;
	assign longIrq = longIrq_q;
	assign stackError = stackError_q;

endmodule : program_sequencer

// ---- tb/program_sequencer_asserts.sv ----
`timescale 1ns/1ps
module program_sequencer_asserts
	import program_sequencer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cmdValid,
	input seq_cmd_type cmd,
	input wire logic cmdReady,
	input wire logic irqTaken,
	input irq_vec_type irqVec,
	input wire logic decodeFirstOfTwo,
	input wire logic decodeAbort,
	input wire logic [ADDR_W-1:0] fetchAddr,
	input wire logic [ADDR_W-1:0] program_counter,
	input wire logic [WORD_W-1:0] status_word,
	input wire logic [WORD_W-1:0] loop_count_reg,
	input wire logic [ADDR_W-1:0] loop_end_address_reg,
	input wire logic [SP_W-1:0] stackPointer,
	input wire logic stackError
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire take = cmdValid && cmdReady;
	sequence irqFetch;
		fetchAddr == irqVec.first ##1 fetchAddr == irqVec.second;
	endsequence
	call_push_a: assert property (take && cmd.op == OP_CALL && stackPointer != SP_FULL |=>
		program_counter == $past(cmd.target) && stackPointer == $past(stackPointer) + SP_STEP)
		else $error("call push wrong");
	irq_fetch_a: assert property (irqTaken |=> irqFetch)
		else $error("interrupt fetch address wrong");
	irq_hold_a: assert property (irqTaken ##1 1'b1 |=> $stable(program_counter) [*2])
		else $error("pc moved during interrupt fetch");
	abort_a: assert property (irqTaken |=> decodeAbort == $past(decodeFirstOfTwo))
		else $error("decode abort wrong");
	loop_start_a: assert property (take && cmd.op == OP_LOOP_START && stackPointer < 4'hD |=>
		!cmdReady && loop_count_reg == $past(cmd.count) && loop_end_address_reg == $past(cmd.loopEnd)
		##1 status_word[LOOP_FLAG_BIT] && stackPointer == $past(stackPointer, 2) + 4'h2)
		else $error("loop start wrong");
	loop_iter_a: assert property (status_word[LOOP_FLAG_BIT] && cmdReady && !cmdValid && !irqTaken
		&& program_counter == loop_end_address_reg && loop_count_reg != LOOP_COUNT_LAST
		|=> loop_count_reg == $past(loop_count_reg) - 32'h1 && $stable(stackPointer))
		else $error("loop iteration wrong");
	full_error_a: assert property (take && cmd.op == OP_CALL && stackPointer == SP_FULL |=>
		stackError && stackPointer == SP_FULL)
		else $error("push on full not flagged");
	error_sticky_a: assert property (stackError |=> stackError)
		else $error("stack error dropped");
endmodule : program_sequencer_asserts

bind program_sequencer program_sequencer_asserts chk (.*);

// ---- tb/irq_fetch_model.sv ----
`timescale 1ns/1ps
module irq_fetch_model
	import program_sequencer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic raise,
	input wire logic jsrSel,
	input wire logic irqTaken,
	input wire logic [ADDR_W-1:0] fetchAddr,
	output logic irqReq,
	output irq_vec_type irqVec,
	output fetched_word_type fetchedWord
);
	initial irqReq = 1'b0;
	assign irqVec = {32'h0000_0040, 32'h0000_0041};
	// request held until taken; non-jump words carry a changing pattern
	always @(posedge ref_clk) begin
		irqReq <= raise | (irqReq & ~irqTaken);
		fetchedWord <= {jsrSel && fetchAddr == irqVec.second, ~fetchAddr};
	end
endmodule : irq_fetch_model

// ---- tb/program_sequencer_tb.sv ----
`timescale 1ns/1ps
module program_sequencer_tb;
	import program_sequencer_pkg::*;
	typedef struct {seq_op_type op; logic [31:0] tgt; logic [3:0] sp;} row_type;
	logic ref_clk = 0, nrst = 0, cmdValid = 0, raise = 0, jsrSel = 0, decodeFirstOfTwo = 0;
	logic cmdReady, irqReq, irqTaken, decodeAbort, fetchValid, longIrq, stackError;
	logic [31:0] decodeAddr = 0, fetchAddr, program_counter, status_word;
	logic [31:0] loop_count_reg, loop_end_address_reg;
	logic [3:0] stackPointer;
	seq_cmd_type cmd = '0;
	irq_vec_type irqVec;
	fetched_word_type fetchedWord;
	int num_errors = 0, tests_run = 0, hits;
	logic [31:0] saved[$];
	row_type rows[5] = '{'{OP_JUMP, 32'h10, 4'h0}, '{OP_CALL, 32'h100, 4'h1},
		'{OP_CALL, 32'h200, 4'h2}, '{OP_RETURN_SUB, 32'h0, 4'h1}, '{OP_RETURN_IRQ, 32'h0, 4'h0}};
	always #2 ref_clk = ~ref_clk;
	program_sequencer dut (.*);
	irq_fetch_model partner (.*);
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic send(seq_op_type op, logic [31:0] tgt, logic [31:0] n);
		// one idle cycle keeps the strobe low between back-to-back commands
		@(negedge ref_clk);
		cmd = '{op, tgt, n, tgt};
		cmdValid = 1;
		@(negedge ref_clk);
		cmdValid = 0;
	endtask : send
	task automatic irq_wait;
		raise = 1;
		@(negedge ref_clk);
		raise = 0;
		for (int k = 0; k < 10 && irqTaken !== 1'b1; k++) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask : irq_wait
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	initial begin
		#4000;
		num_errors++;
		finish_test;
	end
	initial begin
		repeat (2) @(negedge ref_clk);
		chk("pc in reset", PC_RESET, program_counter);
		nrst = 1;
		foreach (rows[i]) begin
			if (rows[i].op == OP_CALL) saved.push_back(program_counter + PC_STEP);
			send(rows[i].op, rows[i].tgt, 32'h0);
			chk("sp", 32'(rows[i].sp), 32'(stackPointer));
			chk("pc", rows[i].op inside {OP_CALL, OP_JUMP} ? rows[i].tgt : saved.pop_back(),
				program_counter);
		end
		$display("row tests done");
		send(OP_JUMP, 32'h300, 32'h0);
		send(OP_LOOP_START, 32'h303, 32'h2);
		chk("count", 32'h2, loop_count_reg);
		chk("end", 32'h303, loop_end_address_reg);
		@(negedge ref_clk);
		chk("loop sp", 32'h2, 32'(stackPointer));
		chk("flag", 32'h1, 32'(status_word[LOOP_FLAG_BIT]));
		hits = 0;
		for (int k = 0; k < 40 && stackPointer !== 4'h0; k++) begin
			if (program_counter === 32'h303) hits++;
			@(negedge ref_clk);
		end
		chk("passes", 32'h2, 32'(hits));
		chk("count back", LOOP_COUNT_RESET, loop_count_reg);
		chk("end back", LOOP_END_RESET, loop_end_address_reg);
		chk("flag back", 32'h0, 32'(status_word[LOOP_FLAG_BIT]));
		$display("loop test done");
		decodeFirstOfTwo = 1;
		decodeAddr = 32'h55;
		irq_wait;
		chk("abort", 32'h1, 32'(decodeAbort));
		chk("first fetch", 32'h40, fetchAddr);
		chk("first valid", 32'h1, 32'(fetchValid));
		chk("refetch pc", 32'h55, program_counter);
		repeat (3) @(negedge ref_clk);
		chk("fast switch", 32'h0, 32'(longIrq));
		chk("fast pc", 32'h55, program_counter);
		@(negedge ref_clk);
		chk("fast sp", 32'h0, 32'(stackPointer));
		decodeFirstOfTwo = 0;
		jsrSel = 1;
		irq_wait;
		repeat (3) @(negedge ref_clk);
		chk("long switch", 32'h1, 32'(longIrq));
		chk("long target", ~32'h41, program_counter);
		@(negedge ref_clk);
		chk("long sp", 32'h1, 32'(stackPointer));
		send(OP_RETURN_IRQ, 32'h0, 32'h0);
		chk("rti sp", 32'h0, 32'(stackPointer));
		$display("interrupt test done");
		repeat (16) send(OP_CALL, 32'h0, 32'h0);
		chk("full sp", 32'(SP_FULL), 32'(stackPointer));
		chk("error", 32'h1, 32'(stackError));
		$display("overflow test done");
		finish_test;
	end
endmodule : program_sequencer_tb
